// ==== stall_pkg.sv ====
package stall_pkg;

    // Clock rate and derived timing.
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned TICK_MS     = 100;
    localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned OL_HOLD_MS  = 100;
    localparam int unsigned OL_HOLD_CYC = CLK_HZ / 1000 * OL_HOLD_MS;
    localparam int unsigned TRIP_S      = 3;
    localparam int unsigned TRIP_CYC    = CLK_HZ * TRIP_S;

    // Register byte offsets.
    localparam logic [7:0] OFS_LEVEL   = 8'h00;
    localparam logic [7:0] OFS_COMP    = 8'h04;
    localparam logic [7:0] OFS_LEVEL2  = 8'h08;
    localparam logic [7:0] OFS_DERATE  = 8'h0C;
    localparam logic [7:0] OFS_OPSEL   = 8'h10;
    localparam logic [7:0] OFS_DELAY   = 8'h14;
    localparam logic [7:0] OFS_LIMQTY  = 8'h18;
    localparam logic [7:0] OFS_OUTFUNC = 8'h1C;
    localparam logic [7:0] OFS_STATUS  = 8'h20;
    localparam logic [7:0] OFS_CTRL    = 8'h24;

    // Setting encodings: levels in 0.1 %, frequencies in 0.1 Hz, time 0.1 s.
    localparam logic [15:0] SENTINEL      = 16'h270F;
    localparam logic [15:0] LEVEL_MAX     = 16'h07D0;
    localparam logic [15:0] FREQ_MAX      = 16'h0FA0;
    localparam logic [15:0] DELAY_MAX     = 16'h00FA;
    localparam logic [15:0] PCT_100       = 16'h03E8;
    localparam logic [15:0] FREQ_TRIP     = 16'h000A;
    localparam logic [15:0] FREQ_NO_TORQ  = 16'h0032;
    localparam logic [15:0] FAST_LIMIT    = 16'h0834;
    localparam logic [7:0]  SEL_DRIVE     = 8'h64;
    localparam logic [7:0]  SEL_REGEN     = 8'h65;
    localparam logic [7:0]  SEL_BITS_MAX  = 8'h1F;
    localparam logic [7:0]  FUNC_OL_POS   = 8'h03;
    localparam logic [7:0]  FUNC_OL_NEG   = 8'h67;

    // Reset values.
    localparam logic [15:0] RST_LEVEL   = 16'h05DC;
    localparam logic [15:0] RST_COMP    = 16'h270F;
    localparam logic [15:0] RST_LEVEL2  = 16'h270F;
    localparam logic [15:0] RST_DERATE  = 16'h0258;
    localparam logic [7:0]  RST_OPSEL   = 8'h00;
    localparam logic [15:0] RST_DELAY   = 16'h0000;
    localparam logic        RST_LIMQTY  = 1'b0;
    localparam logic [7:0]  RST_OUTFUNC = 8'h00;

    // Status and control field positions.
    localparam int unsigned ST_OL     = 16;
    localparam int unsigned ST_TRIP   = 17;
    localparam int unsigned ST_ACTIVE = 18;
    localparam int unsigned ST_SHUT   = 19;
    localparam int unsigned CTRL_CLR  = 0;

    typedef enum logic [1:0] {ST_CONST, ST_ACCEL, ST_DECEL} ramp_state_t;
    typedef enum logic [1:0] {
        ACT_FOLLOW, ACT_DECEL, ACT_ACCEL, ACT_RAISE_MAX
    } ramp_action_t;

    typedef struct packed {
        logic [15:0] level;
        logic [15:0] comp;
        logic [15:0] level2;
        logic [15:0] derate;
        logic [7:0]  opsel;
        logic [15:0] delay;
        logic        limqty;
        logic [7:0]  outfunc;
    } settings_t;

    typedef struct packed {
        logic [15:0] output_current;
        logic [15:0] torque_current;
        logic [15:0] output_freq;
        ramp_state_t ramp_state;
        logic        regenerating;
        logic        regen_avoid;
        logic        overvoltage_stall;
    } drive_meas_t;

endpackage

// ==== stall_prevention_supervisor.sv ====
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/10ps
module stall_prevention_supervisor #(
    parameter int unsigned TICK_CYC    = stall_pkg::TICK_CYC,
    parameter int unsigned OL_HOLD_CYC = stall_pkg::OL_HOLD_CYC,
    parameter int unsigned TRIP_CYC    = stall_pkg::TRIP_CYC
) (
    // Clock and reset.
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave.
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Drive measurements and controls.
    input  wire stall_pkg::drive_meas_t    meas,
    input  wire logic                      second_function_select,
    input  wire logic                      write_lock,
    // Supervisor outputs.
    output stall_pkg::ramp_action_t        ramp_action,
    output logic                           overload_flag,
    output logic                           open_collector_output0,
    output logic                           stall_trip_fault,
    output logic                           output_shutoff,
    output logic                           stop_request
);

    stall_pkg::settings_t    cfg_ff;
    logic [31:0]             rdata_ff;
    logic                    stall_ff;
    stall_pkg::ramp_action_t act_ff;
    logic                    ol_ff;
    logic                    trip_ff;
    logic                    shut_ff;
    logic                    stop_ff;
    logic                    oc0_ff;
    logic [23:0]             tick_cnt_ff;
    logic                    tick_ff;
    logic [15:0]             delay_cnt_ff;
    logic [23:0]             hold_cnt_ff;
    logic [24:0]             trip_cnt_ff;
    logic                    wr_en;
    logic                    rd_setup;
    logic                    clr_trip;
    logic [15:0]             base_level;
    logic [15:0]             eff_level;
    logic [15:0]             qty;
    logic [4:0]              sel_bits;
    logic                    phase_ok;
    logic                    torque_off;
    logic                    nxt_stall;
    logic                    ol_cond;
    logic                    ol_due;
    logic                    fast_trip;
    stall_pkg::ramp_action_t nxt_act;

    // Levels are zero, 0.1 to 200 percent, optionally the 9999 sentinel.
    function automatic logic level_ok(input logic [15:0] v,
                                      input logic allow_sentinel);
        return (v <= stall_pkg::LEVEL_MAX) ||
               (allow_sentinel && v == stall_pkg::SENTINEL);
    endfunction

    // Values 0 to 31 are used as bits; 100 and 101 are per-direction presets.
    function automatic logic [4:0] decode_sel(input logic [7:0] s,
                                              input logic regen);
        if (s == stall_pkg::SEL_REGEN && regen) begin
            return 5'h01;
        end
        if (s <= stall_pkg::SEL_BITS_MAX) begin
            return s[4:0];
        end
        return 5'h00;
    endfunction

    // High-frequency derating of the stall level, all in 0.1 units.
    function automatic logic [15:0] derate(input logic [15:0] l,
                                           input logic [15:0] c,
                                           input logic [15:0] f,
                                           input logic [15:0] fo);
        logic signed [47:0] ls;
        logic signed [47:0] cs;
        logic signed [47:0] fl;
        logic signed [47:0] a;
        logic signed [47:0] b;
        logic signed [47:0] den;
        logic signed [47:0] r;
        // Signed throughout, so a factor below 100 percent divides correctly.
        ls = 48'(l);
        cs = 48'(c) - 48'(stall_pkg::PCT_100);
        fl = ls * $signed(48'(f));
        if (c == stall_pkg::SENTINEL || fo <= f || fo == 16'h0000) begin
            return l;
        end
        a = fl / $signed(48'(fo));
        b = fl / $signed(48'(stall_pkg::FREQ_MAX));
        den = (ls - b) * $signed(48'(stall_pkg::PCT_100));
        if (den <= 0) begin
            return l;
        end
        r = a + (b * (ls - a) * cs) / den;
        if (r < 0) begin
            return 16'h0000;
        end
        return (r > 48'(16'hFFFF)) ? 16'hFFFF : r[15:0];
    endfunction

    // APB decode; the slave never waits, only an address above OFS_CTRL errors, a locked write does not.
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign clr_trip = wr_en && paddr == stall_pkg::OFS_CTRL &&
                      pwdata[stall_pkg::CTRL_CLR];
    assign pslverr  = psel && penable && paddr > stall_pkg::OFS_CTRL;
    assign prdata   = rdata_ff;

    // Setting registers; out-of-range values are not accepted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff.level   <= stall_pkg::RST_LEVEL;
            cfg_ff.comp    <= stall_pkg::RST_COMP;
            cfg_ff.level2  <= stall_pkg::RST_LEVEL2;
            cfg_ff.derate  <= stall_pkg::RST_DERATE;
            cfg_ff.opsel   <= stall_pkg::RST_OPSEL;
            cfg_ff.delay   <= stall_pkg::RST_DELAY;
            cfg_ff.limqty  <= stall_pkg::RST_LIMQTY;
            cfg_ff.outfunc <= stall_pkg::RST_OUTFUNC;
        end else if (wr_en) begin
            if (paddr == stall_pkg::OFS_LEVEL &&
                level_ok(pwdata[15:0], 1'b0) && pwdata[31:16] == 16'h0000) begin
                cfg_ff.level <= pwdata[15:0];
            end else if (!write_lock && pwdata[31:16] == 16'h0000) begin
                if (paddr == stall_pkg::OFS_COMP &&
                    level_ok(pwdata[15:0], 1'b1)) begin
                    cfg_ff.comp <= pwdata[15:0];
                end else if (paddr == stall_pkg::OFS_LEVEL2 &&
                             level_ok(pwdata[15:0], 1'b1)) begin
                    cfg_ff.level2 <= pwdata[15:0];
                end else if (paddr == stall_pkg::OFS_DERATE &&
                             pwdata[15:0] <= stall_pkg::FREQ_MAX) begin
                    cfg_ff.derate <= pwdata[15:0];
                end else if (paddr == stall_pkg::OFS_OPSEL &&
                             pwdata[15:8] == 8'h00 &&
                             (pwdata[7:0] <= stall_pkg::SEL_BITS_MAX ||
                              pwdata[7:0] == stall_pkg::SEL_DRIVE ||
                              pwdata[7:0] == stall_pkg::SEL_REGEN)) begin
                    cfg_ff.opsel <= pwdata[7:0];
                end else if (paddr == stall_pkg::OFS_DELAY &&
                             (pwdata[15:0] <= stall_pkg::DELAY_MAX ||
                              pwdata[15:0] == stall_pkg::SENTINEL)) begin
                    cfg_ff.delay <= pwdata[15:0];
                end else if (paddr == stall_pkg::OFS_LIMQTY &&
                             pwdata[15:1] == 15'h0000) begin
                    cfg_ff.limqty <= pwdata[0];
                end else if (paddr == stall_pkg::OFS_OUTFUNC &&
                             pwdata[15:8] == 8'h00) begin
                    cfg_ff.outfunc <= pwdata[7:0];
                end
            end
        end
    end

    // Read data is captured in the setup phase and shown in the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            if (paddr == stall_pkg::OFS_LEVEL) begin
                rdata_ff <= {16'h0000, cfg_ff.level};
            end else if (paddr == stall_pkg::OFS_COMP) begin
                rdata_ff <= {16'h0000, cfg_ff.comp};
            end else if (paddr == stall_pkg::OFS_LEVEL2) begin
                rdata_ff <= {16'h0000, cfg_ff.level2};
            end else if (paddr == stall_pkg::OFS_DERATE) begin
                rdata_ff <= {16'h0000, cfg_ff.derate};
            end else if (paddr == stall_pkg::OFS_OPSEL) begin
                rdata_ff <= {24'h00_0000, cfg_ff.opsel};
            end else if (paddr == stall_pkg::OFS_DELAY) begin
                rdata_ff <= {16'h0000, cfg_ff.delay};
            end else if (paddr == stall_pkg::OFS_LIMQTY) begin
                rdata_ff <= {31'h0000_0000, cfg_ff.limqty};
            end else if (paddr == stall_pkg::OFS_OUTFUNC) begin
                rdata_ff <= {24'h00_0000, cfg_ff.outfunc};
            end else if (paddr == stall_pkg::OFS_STATUS) begin
                rdata_ff <= {12'h000, shut_ff, stall_ff, trip_ff, ol_ff,
                             eff_level};
            end else begin
                rdata_ff <= 32'h0000_0000;
            end
        end
    end

    // Level selection, derating and the compared quantity.
    assign base_level = (second_function_select &&
                         cfg_ff.level2 != stall_pkg::SENTINEL) ?
                        cfg_ff.level2 : cfg_ff.level;
    assign eff_level  = derate(base_level, cfg_ff.comp, cfg_ff.derate,
                               meas.output_freq);
    assign qty        = cfg_ff.limqty ? meas.torque_current
                                      : meas.output_current;
    assign sel_bits   = decode_sel(cfg_ff.opsel, meas.regenerating);
    assign torque_off = cfg_ff.limqty && meas.ramp_state == stall_pkg::ST_DECEL
                        && meas.output_freq <= stall_pkg::FREQ_NO_TORQ;

    // Per-phase enables of stall prevention.
    always_comb begin
        case (meas.ramp_state)
            stall_pkg::ST_ACCEL: phase_ok = !sel_bits[1];
            stall_pkg::ST_DECEL: phase_ok = !sel_bits[3];
            default:             phase_ok = !sel_bits[2];
        endcase
    end

    assign nxt_stall = phase_ok && !torque_off && base_level != 16'h0000 &&
                       qty > eff_level;

    // Frequency action while stall prevention is active.
    always_comb begin
        nxt_act = stall_pkg::ACT_FOLLOW;
        if (nxt_stall) begin
            if (cfg_ff.limqty && meas.regenerating) begin
                nxt_act = stall_pkg::ACT_RAISE_MAX;
            end else if (meas.ramp_state == stall_pkg::ST_DECEL) begin
                nxt_act = stall_pkg::ACT_ACCEL;
            end else begin
                nxt_act = stall_pkg::ACT_DECEL;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_ff <= 1'b0;
            act_ff   <= stall_pkg::ACT_FOLLOW;
        end else begin
            stall_ff <= nxt_stall;
            act_ff   <= nxt_act;
        end
    end
    assign ramp_action = act_ff;

    // Divider giving a 0.1 s enable pulse for the flag delay.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_ff <= 24'h00_0000;
            tick_ff     <= 1'b0;
        end else begin
            tick_ff     <= tick_cnt_ff == 24'(TICK_CYC - 1);
            tick_cnt_ff <= (tick_cnt_ff == 24'(TICK_CYC - 1)) ?
                           24'h00_0000 : tick_cnt_ff + 24'h00_0001;
        end
    end

    // Flag condition and delay timer in 0.1 s steps.
    assign ol_cond = stall_ff || meas.regen_avoid ||
                     meas.overvoltage_stall;
    assign ol_due  = cfg_ff.delay != stall_pkg::SENTINEL &&
                     delay_cnt_ff >= cfg_ff.delay;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_cnt_ff <= 16'h0000;
        end else if (!ol_cond) begin
            delay_cnt_ff <= 16'h0000;
        end else if (tick_ff && !ol_due &&
                     delay_cnt_ff != stall_pkg::SENTINEL) begin
            delay_cnt_ff <= delay_cnt_ff + 16'h0001;
        end
    end

    // Flag with minimum on-time; it falls only once the condition is gone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ol_ff       <= 1'b0;
            hold_cnt_ff <= 24'h00_0000;
        end else if (ol_cond && ol_due) begin
            ol_ff <= 1'b1;
            if (!ol_ff) begin
                hold_cnt_ff <= 24'h00_0000;
            end else if (hold_cnt_ff != 24'(OL_HOLD_CYC)) begin
                hold_cnt_ff <= hold_cnt_ff + 24'h00_0001;
            end
        end else if (ol_ff) begin
            if (hold_cnt_ff >= 24'(OL_HOLD_CYC)) begin
                ol_ff <= 1'b0;
            end else begin
                hold_cnt_ff <= hold_cnt_ff + 24'h00_0001;
            end
        end
    end
    assign overload_flag = ol_ff;

    // Output terminal routing and stop on flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc0_ff  <= 1'b0;
            stop_ff <= 1'b0;
        end else begin
            oc0_ff  <= (cfg_ff.outfunc == stall_pkg::FUNC_OL_POS && ol_ff) ||
                       (cfg_ff.outfunc == stall_pkg::FUNC_OL_NEG &&
                        !ol_ff);
            stop_ff <= sel_bits[4] && ol_ff;
        end
    end
    assign open_collector_output0 = oc0_ff;
    assign stop_request           = stop_ff;

    // Low-frequency stall timer and sticky trip; a new trip beats the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_cnt_ff <= 25'h000_0000;
            trip_ff     <= 1'b0;
        end else begin
            if (stall_ff && meas.output_freq <= stall_pkg::FREQ_TRIP) begin
                if (trip_cnt_ff != 25'(TRIP_CYC)) begin
                    trip_cnt_ff <= trip_cnt_ff + 25'h000_0001;
                end
            end else begin
                trip_cnt_ff <= 25'h000_0000;
            end
            if (stall_ff && meas.output_freq <= stall_pkg::FREQ_TRIP &&
                trip_cnt_ff == 25'(TRIP_CYC - 1)) begin
                trip_ff <= 1'b1;
            end else if (clr_trip) begin
                trip_ff <= 1'b0;
            end
        end
    end
    assign stall_trip_fault = trip_ff;

    // Output shut-off from fast current limit or trip.
    assign fast_trip = !sel_bits[0] &&
                       meas.output_current > stall_pkg::FAST_LIMIT;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shut_ff <= 1'b0;
        end else begin
            shut_ff <= fast_trip || trip_ff;
        end
    end
    assign output_shutoff = shut_ff;

    // Checks.
    sequence s_ol_rise;
        !ol_ff ##1 ol_ff;
    endsequence

    chk_ol_min_hold: assert property (@(posedge pclk) disable iff (!presetn)
        s_ol_rise |-> ol_ff [*8])
        else $error("Overload flag fell too soon.");
    chk_ol_hold_cnt: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ol_ff) |-> $past(hold_cnt_ff) >= 24'(OL_HOLD_CYC))
        else $error("Overload flag fell before its hold time.");
    chk_ol_never: assert property (@(posedge pclk) disable iff (!presetn)
        $past(cfg_ff.delay) == stall_pkg::SENTINEL &&
        cfg_ff.delay == stall_pkg::SENTINEL && $rose(ol_ff) |-> 1'b0)
        else $error("Overload flag rose with delay disabled.");
    chk_ol_immediate: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff.delay == 16'h0000 && ol_cond |=> ol_ff)
        else $error("Overload flag not immediate.");
    chk_ol_regen: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff.delay == 16'h0000 && meas.regen_avoid |=> ol_ff)
        else $error("Regeneration avoidance did not raise flag.");
    chk_delay_restart: assert property (@(posedge pclk) disable iff (!presetn)
        !ol_cond |=> delay_cnt_ff == 16'h0000)
        else $error("Delay timer kept counting.");
    chk_oc0_route: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_ff.outfunc == stall_pkg::FUNC_OL_NEG && $stable(cfg_ff.outfunc)
        |-> oc0_ff == !$past(ol_ff))
        else $error("Negative routing wrong.");
    chk_trip_set: assert property (@(posedge pclk) disable iff (!presetn)
        trip_ff |=> shut_ff)
        else $error("Trip did not shut output.");
    chk_fast_limit: assert property (@(posedge pclk) disable iff (!presetn)
        fast_trip |=> output_shutoff)
        else $error("Fast limit did not shut output.");
    chk_decel_action: assert property (@(posedge pclk) disable iff (!presetn)
        nxt_stall && !meas.regenerating &&
        meas.ramp_state == stall_pkg::ST_DECEL
        |=> ramp_action == stall_pkg::ACT_ACCEL)
        else $error("Deceleration not reversed.");
    chk_torque_low: assert property (@(posedge pclk) disable iff (!presetn)
        torque_off |=> !stall_ff)
        else $error("Torque limit active at low decel frequency.");
    chk_level_disable: assert property (@(posedge pclk) disable iff (!presetn)
        base_level == 16'h0000 |=> !stall_ff)
        else $error("Stall active with zero level.");

endmodule

// ==== drive_model.sv ====
`timescale 1ns/10ps
// Power stage model: frequency follows the ramp action, stops on shutoff.
module drive_model (
    // Clock and reset.
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // Load and supervisor commands.
    input  wire logic [15:0]             cur,
    input  wire stall_pkg::ramp_state_t  ramp,
    input  wire stall_pkg::ramp_action_t act,
    input  wire logic                    shut,
    input  wire logic [2:0]              flags,
    // Measurements.
    output stall_pkg::drive_meas_t       meas
);
    logic [15:0] freq_ff;
    // Start at 2 Hz so a stall reaches the 1 Hz trip zone quickly.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) freq_ff <= 16'h0014;
        else if (shut) freq_ff <= 16'h0000;
        else if (act == stall_pkg::ACT_DECEL && freq_ff != 16'h0000)
            freq_ff <= freq_ff - 16'h0001;
        else if (act == stall_pkg::ACT_ACCEL) freq_ff <= freq_ff + 16'h0001;
    end
    assign meas = '{cur, cur, freq_ff, ramp, flags[2], flags[1], flags[0]};
endmodule

// ==== tb_stall_prevention_supervisor.sv ====
`timescale 1ns/10ps
module tb_stall_prevention_supervisor;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic sfs, wlock, shut, flag, oc0, trip, stop;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata, rd;
    logic [15:0]             cur;
    logic [2:0]              flags;
    stall_pkg::ramp_state_t  ramp;
    stall_pkg::ramp_action_t act;
    stall_pkg::drive_meas_t  meas;
    int                      error_cnt, num_checks, n;
    row_t                    rows[14];
    stall_prevention_supervisor #(.TICK_CYC(10), .OL_HOLD_CYC(10),
        .TRIP_CYC(30)) u_stall_prevention_supervisor (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .meas, .second_function_select(sfs), .write_lock(wlock),
        .ramp_action(act), .overload_flag(flag), .open_collector_output0(oc0),
        .stall_trip_fault(trip), .output_shutoff(shut), .stop_request(stop));
    drive_model u_drive_model (.pclk, .presetn, .cur, .ramp, .act, .shut,
        .flags, .meas);
    // Clock of 100 ns period.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rst();
        presetn <= 1'b0;
        cur <= 16'h0000;
        ramp <= stall_pkg::ST_CONST;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask
    // The watchdog ends a hung run as a failure.
    initial begin
        #3_000_000;
        error_cnt++;
        final_report();
    end
    // Register rows, then drive-side cases.
    initial begin
        {presetn, psel, penable, pwrite, sfs, wlock} = 6'h00;
        {paddr, pwdata, cur} = 56'h0;
        flags = 3'h0;
        ramp = stall_pkg::ST_CONST;
        error_cnt = 0;
        num_checks = 0;
        rows = '{'{1'b0, 8'h00, 32'h5DC}, '{1'b0, 8'h04, 32'h270F},
            '{1'b0, 8'h08, 32'h270F}, '{1'b0, 8'h0C, 32'h258},
            '{1'b0, 8'h10, 32'h0}, '{1'b1, 8'h00, 32'h7D0},
            '{1'b1, 8'h00, 32'h7D1}, '{1'b0, 8'h00, 32'h7D0},
            '{1'b1, 8'h0C, 32'hFA1}, '{1'b0, 8'h0C, 32'h258},
            '{1'b1, 8'h10, 32'h65}, '{1'b1, 8'h10, 32'h20},
            '{1'b0, 8'h10, 32'h65}, '{1'b0, 8'h28, 32'h0}};
        @(posedge pclk);
        rst();
        // Settings are written and read back.
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                check(rd, rows[i].d);
        end
        check({31'h0, rerr}, 32'h1);
        wlock <= 1'b1;
        apb(1'b1, 8'h0C, 32'h64);
        apb(1'b1, 8'h00, 32'h5DC);
        apb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h258);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h5DC);
        wlock <= 1'b0;
        apb(1'b1, 8'h1C, 32'h3);
        apb(1'b1, 8'h10, 32'h10);
        cur <= 16'h05DD;
        ramp <= stall_pkg::ST_ACCEL;
        repeat (4) @(posedge pclk);
        check(act, stall_pkg::ACT_DECEL);
        check({31'h0, flag & oc0}, 32'h1);
        check({31'h0, stop}, 32'h1);
        ramp <= stall_pkg::ST_DECEL;
        repeat (2) @(posedge pclk);
        check(act, stall_pkg::ACT_ACCEL);
        cur <= 16'h05DC;
        repeat (2) @(posedge pclk);
        check({31'h0, flag}, 32'h1);
        repeat (12) @(posedge pclk);
        check({31'h0, flag}, 32'h0);
        apb(1'b1, 8'h1C, 32'h67);
        @(posedge pclk);
        check({31'h0, oc0}, 32'h1);
        apb(1'b1, 8'h14, 32'h3);
        ramp <= stall_pkg::ST_CONST;
        cur <= 16'h05DD;
        repeat (10) @(posedge pclk);
        check({31'h0, flag}, 32'h0);
        cur <= 16'h0000;
        repeat (2) @(posedge pclk);
        cur <= 16'h05DD;
        repeat (15) @(posedge pclk);
        check({31'h0, flag}, 32'h0);
        repeat (20) @(posedge pclk);
        check({31'h0, flag}, 32'h1);
        rst();
        cur <= 16'h05DD;
        ramp <= stall_pkg::ST_ACCEL;
        n = 0;
        while (trip !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        // Shut-off follows the trip by one edge.
        @(posedge pclk);
        check({31'h0, trip & shut}, 32'h1);
        // About 11 edges to slow from 2 Hz to 1 Hz, then 30 stalled edges.
        check({31'h0, n >= 41 && n <= 43}, 32'h1);
        cur <= 16'h0000;
        apb(1'b1, 8'h24, 32'h1);
        check({31'h0, trip}, 32'h0);
        rst();
        cur <= 16'h0835;
        repeat (3) @(posedge pclk);
        check({31'h0, shut}, 32'h1);
        // Derating, second level, regeneration and torque-limit cases.
        rst();
        apb(1'b1, 8'h0C, 32'hA);
        apb(1'b1, 8'h04, 32'h3E8);
        apb(1'b0, 8'h20, 32'h0);
        check({16'h0, rd[15:0]}, 32'h2EE);
        apb(1'b1, 8'h04, 32'h270F);
        apb(1'b0, 8'h20, 32'h0);
        check({16'h0, rd[15:0]}, 32'h5DC);
        apb(1'b1, 8'h08, 32'h7D0);
        sfs <= 1'b1;
        apb(1'b0, 8'h20, 32'h0);
        check({16'h0, rd[15:0]}, 32'h7D0);
        apb(1'b1, 8'h08, 32'h0);
        cur <= 16'h05DD;
        repeat (2) @(posedge pclk);
        check(act, stall_pkg::ACT_FOLLOW);
        flags <= 3'b010;
        repeat (2) @(posedge pclk);
        check({31'h0, flag}, 32'h1);
        sfs <= 1'b0;
        flags <= 3'b100;
        apb(1'b1, 8'h18, 32'h1);
        repeat (2) @(posedge pclk);
        check(act, stall_pkg::ACT_RAISE_MAX);
        flags <= 3'b000;
        ramp <= stall_pkg::ST_DECEL;
        repeat (2) @(posedge pclk);
        check(act, stall_pkg::ACT_FOLLOW);
        final_report();
    end
endmodule
